// file: design/trigger_and_operation_status.sv
// Purpose: bus triggered level sequencer with its operation status registers
// Assumes: commands come from command decode logic on ref_clk; status pins are asynchronous
// Notes:   one command per cycle; reads answer on the next cycle
`timescale 1ns/1ns
`default_nettype none
`include "fire_cmd_status_defs.svh"

// Functional notes
// R1 - trigger commands act only in fixed mode
// R2 - cancel abandons trigger, reloads pending levels
// R3 - cancel clears awaiting-event flag
// R4 - continuous arming re-arms right after cancel
// R5 - cancel at power-up, recall and reset
// R6 - arm lets next fire apply pending level
// R7 - unarmed fires are ignored entirely
// R8 - continuous arming keeps logic armed
// R9 - controller arms before each fire otherwise
// R10 - accepted fire applies programmed pending level
// R11 - accepted fire clears flag and disarms
// R12 - continuous mode re-arms, flag returns high
// R13 - source select accepts and reports bus only
// R14 - condition register is live and read-only
// R15 - filters writable; preset clears falling filter
// R16 - event latches; read or clear-status clears
// R17 - enable register is a writable mask
// R18 - enabled events OR into status bit 7
// R19 - condition bits 0, 5, 8, 10
// R20 - falling filter catches 1-to-0 changes
// R21 - rising filter catches 0-to-1 changes
// R22 - power-up: rising ones, others zero
// R23 - filter writes can themselves set events
// R24 - 16-bit registers; unassigned bits read zero
// R25 - two-state trigger; flag equals armed state
module trigger_and_operation_status
  import fire_cmd_status_pkg::*;
#(
  parameter int LEVEL_W = 16
) (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               fixedMode,
  input  wire logic               calBusyPin,
  input  wire logic               voltLimitedPin,
  input  wire logic               currLimitedPin,
  input  wire logic               cmdValid,
  input  wire logic [4:0]         cmdCode,
  input  wire logic [15:0]        cmdData,
  input  wire logic [LEVEL_W-1:0] immAmpLevel,
  input  wire logic [LEVEL_W-1:0] immPotLevel,
  output logic                    awaitingEvent,
  output logic [LEVEL_W-1:0]      outAmpLevel,
  output logic [LEVEL_W-1:0]      outPotLevel,
  output logic                    ampApply,
  output logic                    potApply,
  output logic                    respValid,
  output logic [15:0]             respData,
  output logic                    cmdReject,
  output logic [`STB_W-1:0]       statusByte
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  fire_cmd_state_t           stateFf;
  fire_cmd_state_t           nxt_state;
  logic                  contFf;
  logic                  pwrCancelFf;
  logic [LEVEL_W-1:0]    pendAmpFf;
  logic [LEVEL_W-1:0]    pendPotFf;
  logic                  pendAmpSetFf;
  logic                  pendPotSetFf;
  logic [LEVEL_W-1:0]    outAmpFf;
  logic [LEVEL_W-1:0]    outPotFf;
  logic                  ampApplyFf;
  logic                  potApplyFf;
  logic [2:0]            syncAFf;
  logic [2:0]            syncBFf;
  logic [`OPERATION_SUMMARY_BIT_W-1:0]    condFf;
  logic [`OPERATION_SUMMARY_BIT_W-1:0]    condPrevFf;
  logic [`OPERATION_SUMMARY_BIT_W-1:0]    nxt_cond;
  logic [`OPERATION_SUMMARY_BIT_W-1:0]    riseFf;
  logic [`OPERATION_SUMMARY_BIT_W-1:0]    fallFf;
  logic [`OPERATION_SUMMARY_BIT_W-1:0]    enableFf;
  logic [`OPERATION_SUMMARY_BIT_W-1:0]    events;
  logic [`OPERATION_SUMMARY_BIT_W-1:0]    filterSet;
  logic [`OPERATION_SUMMARY_BIT_W-1:0]    wrValue;
  logic                  respValidFf;
  logic [15:0]           respDataFf;
  logic                  cmdRejectFf;
  logic [`STB_W-1:0]     statusByteFf;
  logic                  doCancel;
  logic                  armReq;
  logic                  fireAcc;
  logic                  isRead;

  function automatic logic cmdIs(input logic valid, input logic [4:0] code, input cmd_t which);
    cmdIs = valid && (code == which);
  endfunction

  // ****************************************************************
  // command decode
  // ****************************************************************
  always_comb begin
    doCancel = pwrCancelFf                                         // [R5]
             | (cmdIs(cmdValid, cmdCode, CMD_CANCEL) && fixedMode) // [R1]
             | cmdIs(cmdValid, cmdCode, CMD_RECALL)                // [R5]
             | cmdIs(cmdValid, cmdCode, CMD_RESET_STATE);          // [R5]
    armReq   = cmdIs(cmdValid, cmdCode, CMD_ARM) && fixedMode;     // [R1] [R6]
    fireAcc  = cmdIs(cmdValid, cmdCode, CMD_FIRE) && fixedMode     // [R1]
             && (stateFf == FIRE_CMD_ARMED) && !doCancel;              // [R7]
    wrValue  = cmdData & `OPERATION_SUMMARY_BIT_IMPL_MASK;                          // [R24]
    isRead   = cmdIs(cmdValid, cmdCode, CMD_GET_CONT)
             | cmdIs(cmdValid, cmdCode, CMD_GET_SOURCE)
             | cmdIs(cmdValid, cmdCode, CMD_RD_COND)
             | cmdIs(cmdValid, cmdCode, CMD_RD_RISING)
             | cmdIs(cmdValid, cmdCode, CMD_RD_FALLING)
             | cmdIs(cmdValid, cmdCode, CMD_RD_EVENT)
             | cmdIs(cmdValid, cmdCode, CMD_RD_ENABLE);
  end

  // ****************************************************************
  // power-up cancel
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwrCancelFf <= 1'b1;                                         // [R5]
    end else begin
      pwrCancelFf <= 1'b0;
    end
  end

  // ****************************************************************
  // continuous arming setting
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      contFf <= `CONT_RESET;                                       // [R9]
    end else if (cmdIs(cmdValid, cmdCode, CMD_RESET_STATE)) begin
      contFf <= `CONT_RESET;
    end else if (cmdIs(cmdValid, cmdCode, CMD_SET_CONT)) begin
      contFf <= cmdData[0];                                        // [R8]
    end
  end

  // ****************************************************************
  // trigger state machine
  // ****************************************************************
  always_comb begin
    nxt_state = stateFf;
    case (stateFf)
      FIRE_CMD_IDLE: begin
        if (!doCancel && (armReq || contFf)) begin
          nxt_state = FIRE_CMD_ARMED;                                  // [R4] [R6] [R8] [R12]
        end
      end
      FIRE_CMD_ARMED: begin
        if (doCancel || fireAcc) begin
          nxt_state = FIRE_CMD_IDLE;                                   // [R2] [R11]
        end
      end
      default: begin
        nxt_state = FIRE_CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stateFf <= FIRE_CMD_IDLE;
    end else begin
      stateFf <= nxt_state;                                        // [R25]
    end
  end

  assign awaitingEvent = stateFf;                                  // [R25]

  // ****************************************************************
  // pending levels
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pendAmpFf    <= '0;
      pendPotFf    <= '0;
      pendAmpSetFf <= 1'b0;
      pendPotSetFf <= 1'b0;
    end else if (doCancel) begin
      pendAmpFf    <= immAmpLevel;                                 // [R2]
      pendPotFf    <= immPotLevel;                                 // [R2]
      pendAmpSetFf <= 1'b0;
      pendPotSetFf <= 1'b0;
    end else if (cmdIs(cmdValid, cmdCode, CMD_SET_PEND_I)) begin
      pendAmpFf    <= cmdData[LEVEL_W-1:0];
      pendAmpSetFf <= 1'b1;
    end else if (cmdIs(cmdValid, cmdCode, CMD_SET_PEND_V)) begin
      pendPotFf    <= cmdData[LEVEL_W-1:0];
      pendPotSetFf <= 1'b1;
    end
  end

  // ****************************************************************
  // output level change
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      outAmpFf   <= '0;
      outPotFf   <= '0;
      ampApplyFf <= 1'b0;
      potApplyFf <= 1'b0;
    end else begin
      ampApplyFf <= fireAcc && pendAmpSetFf;                       // [R10]
      potApplyFf <= fireAcc && pendPotSetFf;                       // [R10]
      if (fireAcc && pendAmpSetFf) begin
        outAmpFf <= pendAmpFf;                                     // [R10]
      end
      if (fireAcc && pendPotSetFf) begin
        outPotFf <= pendPotFf;                                     // [R10]
      end
    end
  end

  assign outAmpLevel = outAmpFf;
  assign outPotLevel = outPotFf;
  assign ampApply    = ampApplyFf;
  assign potApply    = potApplyFf;

  // ****************************************************************
  // status pin synchronisers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syncAFf <= 3'h0;
      syncBFf <= 3'h0;
    end else begin
      syncAFf <= {currLimitedPin, voltLimitedPin, calBusyPin};
      syncBFf <= syncAFf;
    end
  end

  // ****************************************************************
  // condition register
  // ****************************************************************
  always_comb begin
    nxt_cond                 = '0;                                 // [R24]
    nxt_cond[`OPERATION_SUMMARY_BIT_CAL_BIT]  = syncBFf[0];                         // [R19]
    nxt_cond[`OPERATION_SUMMARY_BIT_WAIT_BIT] = stateFf;                            // [R19] [R3] [R11]
    nxt_cond[`OPERATION_SUMMARY_BIT_VLIM_BIT] = syncBFf[1];                         // [R19]
    nxt_cond[`OPERATION_SUMMARY_BIT_ILIM_BIT] = syncBFf[2];                         // [R19]
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      condFf     <= '0;
      condPrevFf <= '0;
    end else begin
      condFf     <= nxt_cond;                                      // [R14]
      condPrevFf <= condFf;
    end
  end

  // ****************************************************************
  // filters and enable
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      riseFf   <= `RISE_RESET;                                     // [R22]
      fallFf   <= `FALL_RESET;                                     // [R22]
      enableFf <= `ENABLE_RESET;                                   // [R22]
    end else if (cmdIs(cmdValid, cmdCode, CMD_PRESET)) begin
      riseFf   <= `RISE_RESET;
      fallFf   <= `FALL_RESET;                                     // [R15]
      enableFf <= `ENABLE_RESET;
    end else begin
      if (cmdIs(cmdValid, cmdCode, CMD_WR_RISING)) begin
        riseFf <= wrValue;                                         // [R15]
      end
      if (cmdIs(cmdValid, cmdCode, CMD_WR_FALLING)) begin
        fallFf <= wrValue;                                         // [R15]
      end
      if (cmdIs(cmdValid, cmdCode, CMD_WR_ENABLE)) begin
        enableFf <= wrValue;                                       // [R17]
      end
    end
  end

  // newly opened filter bits report the level already present
  always_comb begin
    filterSet = '0;
    if (cmdIs(cmdValid, cmdCode, CMD_WR_RISING)) begin
      filterSet = wrValue & ~riseFf & condFf;                      // [R23]
    end else if (cmdIs(cmdValid, cmdCode, CMD_WR_FALLING)) begin
      filterSet = wrValue & ~fallFf & ~condFf & `OPERATION_SUMMARY_BIT_IMPL_MASK;   // [R23]
    end
  end

  // ****************************************************************
  // event register
  // ****************************************************************
  operation_summary_bit_event_latch #(
    .W (`OPERATION_SUMMARY_BIT_W)
  ) u_event (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .condNow       (condFf),
    .condPrev      (condPrevFf),
    .risingFilter  (riseFf),                                       // [R21]
    .fallingFilter (fallFf),                                       // [R20]
    .extraSet      (filterSet),
    .clearEvents   (cmdIs(cmdValid, cmdCode, CMD_RD_EVENT)         // [R16]
                    | cmdIs(cmdValid, cmdCode, CMD_CLEAR_STAT)),
    .events        (events)
  );

  // ****************************************************************
  // summary bit
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      statusByteFf <= '0;
    end else begin
      statusByteFf                <= '0;
      statusByteFf[`STB_OPERATION_SUMMARY_BIT_BIT] <= |(events & enableFf);         // [R18]
    end
  end

  assign statusByte = statusByteFf;

  // ****************************************************************
  // readback
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      respValidFf <= 1'b0;
      respDataFf  <= '0;
    end else begin
      respValidFf <= isRead;
      if (isRead) begin
        case (cmdCode)
          CMD_GET_CONT:   respDataFf <= {15'h0000, contFf};
          CMD_GET_SOURCE: respDataFf <= `SOURCE_BUS;               // [R13]
          CMD_RD_COND:    respDataFf <= condFf;                    // [R14]
          CMD_RD_RISING:  respDataFf <= riseFf;
          CMD_RD_FALLING: respDataFf <= fallFf;
          CMD_RD_EVENT:   respDataFf <= events;                    // [R16]
          CMD_RD_ENABLE:  respDataFf <= enableFf;
          default:        respDataFf <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // rejected commands
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmdRejectFf <= 1'b0;
    end else begin
      cmdRejectFf <= (cmdIs(cmdValid, cmdCode, CMD_SET_SOURCE)
                      && (cmdData != `SOURCE_BUS))                 // [R13]
                   || (cmdValid && (cmdCode > CMD_SET_PEND_V));
    end
  end

  assign respValid = respValidFf;
  assign respData  = respDataFf;
  assign cmdReject = cmdRejectFf;

endmodule
`default_nettype wire

// file: design/fire_cmd_status_defs.svh
// Purpose: shared constants of the trigger sequencer and operation status group
// Assumes: 16-bit operation status registers
// Notes:   definitions only
`ifndef FIRE_CMD_STATUS_DEFS_SVH
`define FIRE_CMD_STATUS_DEFS_SVH

// ****************************************************************
// operation status layout
// ****************************************************************
`define OPERATION_SUMMARY_BIT_W          16
`define OPERATION_SUMMARY_BIT_CAL_BIT    0
`define OPERATION_SUMMARY_BIT_WAIT_BIT   5
`define OPERATION_SUMMARY_BIT_VLIM_BIT   8
`define OPERATION_SUMMARY_BIT_ILIM_BIT   10
`define OPERATION_SUMMARY_BIT_IMPL_MASK  16'h0521

// ****************************************************************
// reset values
// ****************************************************************
`define RISE_RESET      16'h0521
`define FALL_RESET      16'h0000
`define EVENT_RESET     16'h0000
`define ENABLE_RESET    16'h0000
`define CONT_RESET      1'b0

// ****************************************************************
// status byte and source code
// ****************************************************************
`define STB_W           8
`define STB_OPERATION_SUMMARY_BIT_BIT    7
`define SOURCE_BUS      16'h0001

`endif

// file: design/fire_cmd_status_pkg.sv
// Purpose: types of the trigger sequencer and operation status group
// Assumes: command codes arrive on a 5-bit command port
// Notes:   trigger states are Gray along idle -> armed
package fire_cmd_status_pkg;

  typedef enum logic [4:0] {
    CMD_CANCEL      = 5'h00,
    CMD_ARM         = 5'h01,
    CMD_FIRE        = 5'h02,
    CMD_SET_CONT    = 5'h03,
    CMD_GET_CONT    = 5'h04,
    CMD_SET_SOURCE  = 5'h05,
    CMD_GET_SOURCE  = 5'h06,
    CMD_RECALL      = 5'h07,
    CMD_RESET_STATE = 5'h08,
    CMD_CLEAR_STAT  = 5'h09,
    CMD_PRESET      = 5'h0A,
    CMD_WR_RISING   = 5'h0B,
    CMD_WR_FALLING  = 5'h0C,
    CMD_WR_ENABLE   = 5'h0D,
    CMD_RD_COND     = 5'h0E,
    CMD_RD_RISING   = 5'h0F,
    CMD_RD_FALLING  = 5'h10,
    CMD_RD_EVENT    = 5'h11,
    CMD_RD_ENABLE   = 5'h12,
    CMD_SET_PEND_I  = 5'h13,
    CMD_SET_PEND_V  = 5'h14
  } cmd_t;

  typedef enum logic {
    FIRE_CMD_IDLE  = 1'b0,
    FIRE_CMD_ARMED = 1'b1
  } fire_cmd_state_t;

endpackage

// file: design/operation_summary_bit_event_latch.sv
// Purpose: transition filtered event latch of the operation status group
// Assumes: condNow and condPrev are registered one cycle apart
// Notes:   a set arriving with a clear wins
`timescale 1ns/1ns
`default_nettype none
`include "fire_cmd_status_defs.svh"

module operation_summary_bit_event_latch #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] condNow,
  input  wire logic [W-1:0] condPrev,
  input  wire logic [W-1:0] risingFilter,
  input  wire logic [W-1:0] fallingFilter,
  input  wire logic [W-1:0] extraSet,
  input  wire logic         clearEvents,
  output logic      [W-1:0] events
);

  logic [W-1:0] eventFf;
  logic [W-1:0] setBits;

  // ****************************************************************
  // transition filter
  // ****************************************************************
  always_comb begin
    setBits = (risingFilter & condNow & ~condPrev)     // [R21]
            | (fallingFilter & ~condNow & condPrev)    // [R20]
            | extraSet;                                // [R23]
  end

  // ****************************************************************
  // event latch
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      eventFf <= W'(`EVENT_RESET);                     // [R22]
    end else if (clearEvents) begin
      eventFf <= setBits;                              // [R16]
    end else begin
      eventFf <= eventFf | setBits;                    // [R16]
    end
  end

  assign events = eventFf;

endmodule
`default_nettype wire

// file: tb/fire_cmd_status_checker.sv
// Purpose: port assertions of the trigger sequencer and status group
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the design top from the testbench file
`timescale 1ns/1ns
`default_nettype none
`include "fire_cmd_status_defs.svh"

module fire_cmd_status_checker
  import fire_cmd_status_pkg::*;
#(
  parameter int LEVEL_W = 16
) (
  input wire logic               ref_clk,
  input wire logic               reset,
  input wire logic               fixedMode,
  input wire logic               calBusyPin,
  input wire logic               voltLimitedPin,
  input wire logic               currLimitedPin,
  input wire logic               cmdValid,
  input wire logic [4:0]         cmdCode,
  input wire logic [15:0]        cmdData,
  input wire logic [LEVEL_W-1:0] immAmpLevel,
  input wire logic [LEVEL_W-1:0] immPotLevel,
  input wire logic               awaitingEvent,
  input wire logic [LEVEL_W-1:0] outAmpLevel,
  input wire logic [LEVEL_W-1:0] outPotLevel,
  input wire logic               ampApply,
  input wire logic               potApply,
  input wire logic               respValid,
  input wire logic [15:0]        respData,
  input wire logic               cmdReject,
  input wire logic [`STB_W-1:0]  statusByte
);
  // ****************************************************************
  // port relations
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_fixed_only: assert property (!fixedMode |=> !(ampApply || potApply))
    else $error("level applied outside fixed mode");
  a_idle_ignores: assert property (!awaitingEvent |=> !(ampApply || potApply))
    else $error("level applied while not armed");
  a_arm_sets: assert property ((cmdValid && cmdCode == CMD_ARM && fixedMode && !$past(reset)) |=> awaitingEvent)
    else $error("arm did not raise awaiting flag");
  a_fire_disarms: assert property ((ampApply || potApply) |-> !awaitingEvent)
    else $error("awaiting flag high at apply");
  a_amp_hold: assert property ($changed(outAmpLevel) |-> ampApply)
    else $error("current level changed without apply");
  a_pot_hold: assert property ($changed(outPotLevel) |-> potApply)
    else $error("voltage level changed without apply");
  a_summary_only: assert property (statusByte[6:0] == 7'h00)
    else $error("status byte bit other than summary set");
  a_source_reject: assert property ((cmdValid && cmdCode == CMD_SET_SOURCE && cmdData != `SOURCE_BUS) |=> cmdReject)
    else $error("bad source not rejected");
  a_read_answer: assert property ((cmdValid && cmdCode inside {CMD_RD_EVENT, CMD_RD_COND}) |=> respValid)
    else $error("read not answered");
endmodule
`default_nettype wire

// file: tb/bus_controller_model.sv
// Purpose: remote controller issuing commands to the block
// Assumes: command taken at the edge where cmdValid is high
// Notes:   fields scrambled once released
`timescale 1ns/1ns
`default_nettype none

module bus_controller_model
  import fire_cmd_status_pkg::*;
(
  input  wire logic        ref_clk,
  output logic             cmdValid,
  output logic [4:0]       cmdCode,
  output logic [15:0]      cmdData
);
  // ****************************************************************
  // command issue
  // ****************************************************************
  initial begin
    cmdValid = 1'b0;
    cmdCode  = 5'h1F;
    cmdData  = 16'h0000;
  end

  task automatic send(input cmd_t code, input logic [15:0] data);
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdCode  <= code;
    cmdData  <= data;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    cmdCode  <= ~code;
    cmdData  <= ~data;
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench of the trigger sequencer and status group
// Assumes: commands from the controller model, pins from the bench
// Notes:   register table first, trigger and status cases after
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench
  import fire_cmd_status_pkg::*;
;
  typedef struct {cmd_t wc; logic [15:0] wd; cmd_t rc; logic [15:0] ex;} row_t;
  logic        ref_clk, reset, fixedMode, calBusyPin, voltLimitedPin, currLimitedPin;
  logic        cmdValid, awaitingEvent, ampApply, potApply, respValid, cmdReject;
  logic [4:0]  cmdCode;
  logic [15:0] cmdData, immAmpLevel, immPotLevel, outAmpLevel, outPotLevel, respData;
  logic [7:0]  statusByte;
  int          errors, numChecks;
  row_t rows [8] = '{'{CMD_WR_RISING, 16'hFFFF, CMD_RD_RISING, 16'h0521}, '{CMD_WR_RISING, 16'h0000,
    CMD_RD_RISING, 16'h0000}, '{CMD_WR_FALLING, 16'hFFFF, CMD_RD_FALLING, 16'h0521}, '{CMD_WR_ENABLE,
    16'hFFFF, CMD_RD_ENABLE, 16'h0521}, '{CMD_WR_ENABLE, 16'h0000, CMD_RD_ENABLE, 16'h0000}, '{CMD_SET_CONT,
    16'h0001, CMD_GET_CONT, 16'h0001}, '{CMD_SET_CONT, 16'h0000, CMD_GET_CONT, 16'h0000}, '{CMD_SET_SOURCE,
    16'h0001, CMD_GET_SOURCE, 16'h0001}};

  bus_controller_model ctrl (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData));
  trigger_and_operation_status #(.LEVEL_W(16)) dut (.ref_clk(ref_clk), .reset(reset), .fixedMode(fixedMode),
    .calBusyPin(calBusyPin), .voltLimitedPin(voltLimitedPin), .currLimitedPin(currLimitedPin),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData), .immAmpLevel(immAmpLevel),
    .immPotLevel(immPotLevel), .awaitingEvent(awaitingEvent), .outAmpLevel(outAmpLevel),
    .outPotLevel(outPotLevel), .ampApply(ampApply), .potApply(potApply), .respValid(respValid),
    .respData(respData), .cmdReject(cmdReject), .statusByte(statusByte));

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task step;
    @(posedge ref_clk);
    #1;
  endtask

  task rd(input cmd_t c, input logic [15:0] e);
    ctrl.send(c, 16'h0000);
    #1;
    `CHK(respValid, 1'b1)
    `CHK(respData, e)
  endtask

  task stop_test;
    $display("checks=%0d errors=%0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    errors++;
    stop_test();
  end

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    errors = 0;
    numChecks = 0;
    reset = 1'b1;
    fixedMode = 1'b1;
    {calBusyPin, voltLimitedPin, currLimitedPin} = 3'b000;
    immAmpLevel = 16'h0042;
    immPotLevel = 16'h0024;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    step();
    `CHK(awaitingEvent, 1'b0)
    foreach (rows[i]) begin
      ctrl.send(rows[i].wc, rows[i].wd);
      rd(rows[i].rc, rows[i].ex);
    end
    // second reset in mid-run
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rd(CMD_RD_RISING, 16'h0521);
    rd(CMD_RD_FALLING, 16'h0000);
    rd(CMD_RD_ENABLE, 16'h0000);
    rd(CMD_RD_EVENT, 16'h0000);
    rd(CMD_GET_CONT, 16'h0000);
    @(posedge ref_clk);
    fixedMode <= 1'b0;
    ctrl.send(CMD_ARM, 16'h0000);
    step();
    `CHK(awaitingEvent, 1'b0)
    fixedMode <= 1'b1;
    ctrl.send(CMD_SET_PEND_I, 16'h1234);
    ctrl.send(CMD_FIRE, 16'h0000);
    #1;
    `CHK({ampApply, outAmpLevel}, {1'b0, 16'h0000})
    ctrl.send(CMD_WR_ENABLE, 16'h0020);
    ctrl.send(CMD_ARM, 16'h0000);
    step();
    `CHK(awaitingEvent, 1'b1)
    ctrl.send(CMD_FIRE, 16'h0000);
    #1;
    `CHK({ampApply, outAmpLevel, awaitingEvent}, {1'b1, 16'h1234, 1'b0})
    repeat (3) step();
    `CHK(statusByte[7], 1'b1)
    rd(CMD_RD_EVENT, 16'h0020);
    rd(CMD_RD_EVENT, 16'h0000);
    repeat (2) step();
    `CHK(statusByte[7], 1'b0)
    ctrl.send(CMD_ARM, 16'h0000);
    @(posedge ref_clk);
    fixedMode <= 1'b0;
    ctrl.send(CMD_FIRE, 16'h0000);
    #1;
    `CHK(ampApply, 1'b0)
    fixedMode <= 1'b1;
    ctrl.send(CMD_SET_PEND_V, 16'hABCD);
    ctrl.send(CMD_FIRE, 16'h0000);
    #1;
    `CHK({potApply, outPotLevel}, {1'b1, 16'hABCD})
    ctrl.send(CMD_SET_CONT, 16'h0001);
    repeat (2) step();
    `CHK(awaitingEvent, 1'b1)
    ctrl.send(CMD_SET_PEND_I, 16'h5555);
    ctrl.send(CMD_FIRE, 16'h0000);
    step();
    `CHK(outAmpLevel, 16'h5555)
    step();
    `CHK(awaitingEvent, 1'b1)
    ctrl.send(CMD_SET_PEND_I, 16'h6666);
    ctrl.send(CMD_FIRE, 16'h0000);
    step();
    `CHK(outAmpLevel, 16'h6666)
    ctrl.send(CMD_CANCEL, 16'h0000);
    repeat (3) step();
    `CHK(awaitingEvent, 1'b1)
    ctrl.send(CMD_FIRE, 16'h0000);
    #1;
    `CHK({ampApply, outAmpLevel}, {1'b0, 16'h6666})
    ctrl.send(CMD_SET_CONT, 16'h0000);
    ctrl.send(CMD_CANCEL, 16'h0000);
    repeat (2) step();
    `CHK(awaitingEvent, 1'b0)
    ctrl.send(CMD_ARM, 16'h0000);
    ctrl.send(CMD_RECALL, 16'h0000);
    repeat (2) step();
    `CHK(awaitingEvent, 1'b0)
    ctrl.send(CMD_SET_SOURCE, 16'h0002);
    #1;
    `CHK(cmdReject, 1'b1)
    rd(CMD_GET_SOURCE, 16'h0001);
    @(posedge ref_clk);
    {calBusyPin, voltLimitedPin, currLimitedPin} <= 3'b111;
    repeat (5) step();
    rd(CMD_RD_COND, 16'h0501);
    ctrl.send(CMD_CLEAR_STAT, 16'h0000);
    ctrl.send(CMD_WR_FALLING, 16'h0400);
    @(posedge ref_clk);
    currLimitedPin <= 1'b0;
    repeat (5) step();
    rd(CMD_RD_EVENT, 16'h0400);
    ctrl.send(CMD_WR_FALLING, 16'h0000);
    ctrl.send(CMD_CLEAR_STAT, 16'h0000);
    ctrl.send(CMD_WR_FALLING, 16'h0400);
    rd(CMD_RD_EVENT, 16'h0400);
    ctrl.send(CMD_PRESET, 16'h0000);
    rd(CMD_RD_FALLING, 16'h0000);
    stop_test();
  end
endmodule

bind trigger_and_operation_status fire_cmd_status_checker #(.LEVEL_W(LEVEL_W)) chk (.ref_clk(ref_clk),
  .reset(reset), .fixedMode(fixedMode), .calBusyPin(calBusyPin), .voltLimitedPin(voltLimitedPin),
  .currLimitedPin(currLimitedPin), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
  .immAmpLevel(immAmpLevel), .immPotLevel(immPotLevel), .awaitingEvent(awaitingEvent),
  .outAmpLevel(outAmpLevel), .outPotLevel(outPotLevel), .ampApply(ampApply), .potApply(potApply),
  .respValid(respValid), .respData(respData), .cmdReject(cmdReject), .statusByte(statusByte));
`default_nettype wire
